/* core/fra_rate_fifo.sv */
// fiber receive rate adaptation fifo, link clock sampled by local clock
module fra_rate_fifo
  import fra_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode
  input wire logic i_fiber,
  // link side
  input wire logic i_link_clk,
  input wire fra_pkg::fra_byte_s i_link,
  // local side
  output fra_pkg::fra_out_s o_rx,
  output logic o_overflow
);
  import fra_pkg::*;

  logic [2:0] clk_sync;
  fra_byte_s lnk_s1, lnk_s2, lnk_cap;
  logic lnk_rise;
  fra_byte_s mem [FRA_DEPTH];
  logic [FRA_AW:0] wptr, rptr, next_wptr, next_rptr;
  logic [2:0] drop_cnt, next_drop_cnt;
  logic [3:0] rd_cnt, next_rd_cnt;
  logic frame_bad, next_frame_bad;
  logic in_frame_d, next_in_frame_d;
  fra_out_s next_rx;
  logic next_overflow;
  logic [FRA_AW:0] level;
  logic full, empty, wr_en, rd_en, skip_idle, rd_slot;
  fra_byte_s head;

  function automatic logic is_idle(input fra_byte_s b);
    return !b.frame;
  endfunction : is_idle

  // link clock and data synchronisers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clk_sync <= 3'h0;
      lnk_s1 <= '0;
      lnk_s2 <= '0;
    end else begin
      clk_sync <= {clk_sync[1:0], i_link_clk};
      lnk_s1 <= i_link;
      lnk_s2 <= lnk_s1;
    end
  end

  assign lnk_rise = clk_sync[1] && !clk_sync[2];
  assign lnk_cap = lnk_s2;
  assign level = wptr - rptr;
  assign full = (level == 4'(FRA_DEPTH));
  assign empty = (level == 4'h0);
  assign head = mem[rptr[FRA_AW-1:0]];
  // idle symbol dropped on write when surplus is present
  assign skip_idle = is_idle(lnk_cap) && (level >= FRA_HIGH_MARK);
  assign wr_en = lnk_rise && i_fiber && !full && !skip_idle
                 && (drop_cnt == FRA_DROP_CNT_INIT);
  assign rd_slot = (rd_cnt == 4'h0);
  assign rd_en = i_fiber && !empty && !lnk_rise && rd_slot;

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_drop_cnt = drop_cnt;
    next_frame_bad = frame_bad;
    next_in_frame_d = in_frame_d;
    next_overflow = 1'b0;
    next_rx = '0;
    if (!i_fiber) begin
      // copper path bypasses the fifo
      next_rx.valid = lnk_rise;
      next_rx.frame = lnk_cap.frame;
      next_rx.data = lnk_cap.data;
      next_wptr = rptr;
      next_drop_cnt = FRA_DROP_CNT_INIT;
    end else begin
      if (wr_en) begin
        next_wptr = wptr + 4'h1;
      end
      // overflow loses four link bytes: the frame byte that finds the fifo full and the next three bytes of any kind
      if (lnk_rise && full && lnk_cap.frame
          && drop_cnt == FRA_DROP_CNT_INIT) begin
        next_drop_cnt = 3'(FRA_DROP_BYTES - 1);
        next_frame_bad = 1'b1;
        next_overflow = 1'b1;
      end else if (lnk_rise && drop_cnt != FRA_DROP_CNT_INIT) begin
        next_drop_cnt = drop_cnt - 3'h1;
      end
      if (rd_en) begin
        next_rptr = rptr + 4'h1;
        next_rx.valid = 1'b1;
        next_rx.frame = head.frame;
        next_rx.data = head.data;
        // frame end carries crc failure if bytes were lost
        if (!head.frame && in_frame_d) begin
          next_rx.crc_err = frame_bad;
          next_frame_bad = next_overflow;
        end
        next_in_frame_d = head.frame;
      end
    end
  end

  // local reader takes one symbol per local symbol time
  always_comb begin
    next_rd_cnt = rd_cnt;
    if (!i_fiber || rd_en || (rd_slot && empty)) begin
      next_rd_cnt = 4'(FRA_RD_CYC - 1);
    end else if (!rd_slot) begin
      next_rd_cnt = rd_cnt - 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_cnt <= 4'(FRA_RD_CYC - 1);
    end else begin
      rd_cnt <= next_rd_cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem[wptr[FRA_AW-1:0]] <= lnk_cap;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      drop_cnt <= FRA_DROP_CNT_INIT;
      frame_bad <= 1'b0;
      in_frame_d <= 1'b0;
      o_rx <= '0;
      o_overflow <= 1'b0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      drop_cnt <= next_drop_cnt;
      frame_bad <= next_frame_bad;
      in_frame_d <= next_in_frame_d;
      o_rx <= next_rx;
      o_overflow <= next_overflow;
    end
  end

  property p_no_frame_drop;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fiber && lnk_rise && lnk_cap.frame && !full
       && drop_cnt == FRA_DROP_CNT_INIT) |=> (wptr == $past(wptr) + 4'h1);
  endproperty
  a_no_frame_drop: assert property (p_no_frame_drop)
    else $error("frame byte not written");

  property p_gap_recover;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fiber && lnk_rise && !lnk_cap.frame && level >= FRA_HIGH_MARK)
      |=> (wptr == $past(wptr));
  endproperty
  a_gap_recover: assert property (p_gap_recover)
    else $error("idle not discarded at gap start");

  property p_drop_four;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_overflow |-> (drop_cnt == 3'(FRA_DROP_BYTES - 1)) && frame_bad;
  endproperty
  a_drop_four: assert property (p_drop_four)
    else $error("overflow did not start four byte loss");

  property p_copper;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!i_fiber && lnk_rise) |=> o_rx.valid && o_rx.data == $past(lnk_cap.data);
  endproperty
  a_copper: assert property (p_copper)
    else $error("copper data not bypassed");

  property p_bound;
    @(posedge i_clk) disable iff (!i_rst_n)
      level <= 4'(FRA_DEPTH);
  endproperty
  a_bound: assert property (p_bound)
    else $error("fifo level out of range");

  property p_read_pace;
    @(posedge i_clk) disable iff (!i_rst_n)
      rd_en |=> !rd_en [*8];
  endproperty
  a_read_pace: assert property (p_read_pace)
    else $error("reads faster than the local symbol rate");

  property p_loss_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fiber && lnk_rise && drop_cnt != FRA_DROP_CNT_INIT)
      |=> (wptr == $past(wptr));
  endproperty
  a_loss_hold: assert property (p_loss_hold)
    else $error("byte written during overflow loss");

  property p_crc_mark;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rd_en && frame_bad && !head.frame && in_frame_d) |=> o_rx.crc_err;
  endproperty
  a_crc_mark: assert property (p_crc_mark)
    else $error("damaged frame end not flagged");

  property p_idle_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fiber && lnk_rise && !lnk_cap.frame && level < FRA_HIGH_MARK
       && drop_cnt == FRA_DROP_CNT_INIT) |=> (wptr == $past(wptr) + 4'h1);
  endproperty
  a_idle_keep: assert property (p_idle_keep)
    else $error("idle below high mark was discarded");
endmodule : fra_rate_fifo

/* core/fra_pkg.sv */
// package for the fiber receive rate adaptation fifo
package fra_pkg;
  localparam int FRA_DW = 8;
  localparam int FRA_AW = 3;
  localparam int FRA_DEPTH = 8;
  localparam logic [FRA_AW:0] FRA_HIGH_MARK = 4'h2;
  localparam int FRA_DROP_BYTES = 4;
  localparam int FRA_RD_CYC = 9;
  localparam logic [2:0] FRA_DROP_CNT_INIT = 3'h0;
  localparam logic [FRA_DW-1:0] FRA_IDLE_BYTE = 8'h00;
  localparam int FRA_CLK_NS = 50;
  localparam int FRA_GAP_SHORT_NS = 144;
  localparam int FRA_GAP_SHORT_SYM = 18;
  localparam int FRA_GAP_LONG_NS = 160;
  localparam int FRA_GAP_LONG_SYM = 20;
  localparam int FRA_GAP_SHORT_CYC = (FRA_GAP_SHORT_NS + FRA_CLK_NS - 1) / FRA_CLK_NS;

  typedef struct packed {
    logic frame;
    logic [FRA_DW-1:0] data;
  } fra_byte_s;

  typedef struct packed {
    logic valid;
    logic frame;
    logic crc_err;
    logic [FRA_DW-1:0] data;
  } fra_out_s;
endpackage : fra_pkg

/* dv/fra_link_partner.sv */
// link partner model sending one byte per link period
module fra_link_partner
  import fra_pkg::*;
(
  // clock
  input wire logic i_clk,
  // link side
  output logic o_link_clk,
  output fra_pkg::fra_byte_s o_link
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_link_clk = 1'b0;
    o_link = '0;
  end
  // data held 6 cycles past the rise
  task automatic send(input logic frame, input logic [FRA_DW-1:0] data);
    o_link <= '{frame: frame, data: data};
    repeat (2) @(posedge i_clk);
    o_link_clk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_link_clk <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : send
endmodule : fra_link_partner

/* dv/tb.sv */
// bench for the fiber receive rate adaptation fifo
module tb;
  import fra_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_fiber = 1'b1;
  logic link_clk;
  fra_byte_s link;
  fra_out_s rx;
  logic ovf;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h41a4_b978;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_ovf = 0;
  int ovf_seen = 0;
  int ovf_base = 0;
  int n_skip = 0;
  logic ovf_ok = 1'b0;
  logic crc_exp = 1'b0;
  logic crc_want = 1'b0;
  logic in_frm = 1'b0;
  always #25 i_clk = ~i_clk;
  fra_link_partner P (.i_clk(i_clk), .o_link_clk(link_clk), .o_link(link));
  fra_rate_fifo DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fiber(i_fiber),
    .i_link_clk(link_clk), .i_link(link), .o_rx(rx), .o_overflow(ovf));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic check(input string what, input logic [7:0] e,
      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // one link symbol; bytes lost to an overflow leave the notes
  task automatic put(input logic frame, input logic [7:0] data);
    if (n_ovf != ovf_seen) begin
      ovf_seen = n_ovf;
      void'(exp_q.pop_back());
      n_skip = FRA_DROP_BYTES - 1;
    end
    if (n_skip > 0) begin
      n_skip--;
    end else if (frame) begin
      exp_q.push_back(data);
    end
    P.send(frame, data);
  endtask : put
  // random frame bytes, then an idle gap of the given length
  task automatic frame(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      lfsr = step(lfsr);
      put(1'b1, lfsr[7:0]);
    end
    for (int k = 0; k < gap; k++) begin
      put(1'b0, FRA_IDLE_BYTE);
    end
  endtask : frame
  // monitor takes the oldest note per frame byte
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      n_errors++;
      end_sim();
    end
    if (ovf === 1'b1) begin
      n_ovf++;
      crc_exp = 1'b1;
    end
    if (i_rst_n && !ovf_ok) check("overflow", 8'h00, {7'h00, ovf});
    if (rx.valid === 1'b1) begin
      crc_want = crc_exp && in_frm && !rx.frame;
      check("crc", {7'h00, crc_want}, {7'h00, rx.crc_err});
      if (in_frm && !rx.frame) crc_exp = 1'b0;
      in_frm = rx.frame;
      if (rx.frame === 1'b1 && exp_q.size() == 0) begin
        check("extra", 8'h00, 8'hff);
      end else if (rx.frame === 1'b1) begin
        check("data", exp_q.pop_front(), rx.data);
      end
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    frame(6, FRA_GAP_SHORT_SYM);
    frame(1, FRA_GAP_SHORT_SYM);
    ovf_base = n_ovf;
    ovf_ok = 1'b1;
    frame(100, FRA_GAP_LONG_SYM);
    ovf_ok = 1'b0;
    check("overflows", 8'h01, {7'h00, n_ovf > ovf_base});
    P.send(1'b0, FRA_IDLE_BYTE);
    i_fiber <= 1'b0;
    frame(5, FRA_GAP_SHORT_SYM);
    repeat (20) @(posedge i_clk);
    check("left", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
endmodule : tb
